// File: hw/tcc_top.sv
// Trigger controller: status feedback handling and fast command generation.
// Behaviour
// - Ready partitions may receive first-level accepts.
// - A busy partition inhibits first-level accepts.
// - Near-full warning holds off accepts until the warning clears.
// - Misalignment flag triggers a readout reset command.
// - Partition error state triggers a broadcast deep reset.
// - Global mode takes only system-wide actions, never per-component ones.
// - Each accept sends 128 algorithm bits and per-partition 4-bit trigger type.
// - Readout reset is forwarded to the event coordinator; start/stop not.
// - Coordinator busy blocks accepts; pipeline may keep running.
// - Dead-time counters run while a near-full inhibit is active.
// - Event counter is 24 bits, counts accepts since last clear, wraps.
// - Crossing counter is 12 bits, 3564 per orbit, cleared once per orbit.
// - Accept travels alone on dedicated channel A.
// - Optional trigger-type word on channel B, 1 us after the accept.
// - Orbit marker and crossing clear are sent synchronously with orbit.
// - Event counter clear is broadcast; optional event number long word.
// - Start and stop trigger are broadcast synchronously.
// - Every accept is tied to one specific crossing.
// - Accepts come from decision logic or operator, sent to all receivers; here a decision accept goes only to partitions whose DECISION bit is set.
// - Readout reset: stop accepts, send reset, wait, clear events, resume.
// - Per-partition launch strobes start channel B commands.
`timescale 1ns/1ps
module tcc_top #(
	parameter int NP        = tcc_pkg::NUM_PART,
	parameter int RST_WAIT  = tcc_pkg::RESET_WAIT_CYC
) (
	input  wire logic                                MCLK,
	input  wire logic                                RST_N,
	input  wire logic                                ORBIT,
	input  wire logic [NP-1:0]                       DECISION,
	input  wire logic [tcc_pkg::ALGO_BITS-1:0]       ALGO_BITS,
	input  wire logic                                OPERATOR_ACCEPT,
	input  wire logic                                OPERATOR_RESET,
	input  wire logic                                START_REQ,
	input  wire logic                                STOP_REQ,
	input  wire logic                                TTYPE_ON_B_EN,
	input  wire logic                                EVNUM_ON_B_EN,
	input  wire logic [NP-1:0]                       PART_ENABLE,
	input  wire logic [NP-1:0]                       PART_READY,
	input  wire logic [NP-1:0]                       PART_BUSY,
	input  wire logic [NP-1:0]                       PART_WARN,
	input  wire logic [NP-1:0]                       PART_MISALIGN,
	input  wire logic [NP-1:0]                       PART_ERROR,
	input  wire logic                                EC_BUSY,
	input  wire logic                                EC_WARN,
	input  wire logic                                EC_MISALIGN,
	output logic      [NP-1:0]                       FIRST_LEVEL_ACCEPT,
	output logic      [NP-1:0]                       LAUNCH,
	output tcc_pkg::tcc_cmd_t                        LAUNCH_CMD,
	output logic                                     B_WORD_VLD,
	output logic      [31:0]                         B_WORD,
	output logic                                     EC_ACCEPT,
	output logic      [tcc_pkg::ALGO_BITS-1:0]       EC_ALGO,
	output logic      [NP*tcc_pkg::TTYPE_BITS-1:0]   EC_TTYPE,
	output logic                                     EC_READOUT_RESET,
	output logic      [tcc_pkg::EVT_BITS-1:0]        EC_EVT_NUM,
	output logic      [tcc_pkg::XING_BITS-1:0]       EC_XING_NUM,
	output logic                                     INHIBIT,
	output logic      [tcc_pkg::DEAD_BITS-1:0]       DEAD_COUNT,
	output logic      [tcc_pkg::DEAD_BITS-1:0]       WARN_DEAD_COUNT,
	output logic                                     RUNNING
);
	localparam int SW = 5 * NP + 3;
	localparam int TW = NP * tcc_pkg::TTYPE_BITS;

	logic [SW-1:0] s_raw;
	logic [SW-1:0] s_sync;
	logic [NP-1:0] rdy, bsy, wrn, mis, err;
	logic          ec_bsy, ec_wrn, ec_mis;
	logic          orbit_d, orbit_q;
	logic          orbit_edge;
	logic [2:0]    ctl_q;
	logic [2:0]    ctl_d;
	logic          opacc_edge, oprst_edge, start_edge, stop_edge;
	logic          stop_q;
	logic          busy_any, warn_any, inhibit_now;
	logic [NP-1:0] fire;
	logic          rst_req;
	logic          deep_req;
	tcc_pkg::tcc_rst_t rst_state;
	logic [$clog2(RST_WAIT+1)-1:0] rst_cnt;
	logic [tcc_pkg::XING_BITS-1:0] xing;
	logic [tcc_pkg::EVT_BITS-1:0]  evt;
	logic          ttype_vld;
	logic [31:0]   b_word_dly;
	logic          pend_start, pend_stop, pend_orbit, pend_xclr;
	logic          mis_q, err_q;

	// Elaboration checks: the channel B word holds at most eight trigger-type nibbles.
	if (NP < 1 || NP > 8) begin : g_np_check
		$error("NP must be 1..8 to fit the 32-bit channel B word");
	end
	if (RST_WAIT < 1) begin : g_wait_check
		$error("RST_WAIT must be positive");
	end

	// Status from pins crosses into MCLK; a fixed depth keeps the reaction latency constant.
	assign s_raw = {EC_MISALIGN, EC_WARN, EC_BUSY, PART_ERROR, PART_MISALIGN, PART_WARN, PART_BUSY, PART_READY};
	tcc_sync #(.W(SW)) u_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.din   (s_raw),
		.dout  (s_sync)
	);

	assign rdy    = s_sync[NP-1:0];
	assign bsy    = s_sync[2*NP-1:NP];
	assign wrn    = s_sync[3*NP-1:2*NP];
	assign mis    = s_sync[4*NP-1:3*NP];
	assign err    = s_sync[5*NP-1:4*NP];
	assign ec_bsy = s_sync[5*NP];
	assign ec_wrn = s_sync[5*NP+1];
	assign ec_mis = s_sync[5*NP+2];

	// Orbit and operator pins are also asynchronous.
	tcc_sync #(.W(4)) u_sync_ctl (
		.clk   (MCLK),
		.rst_n (RST_N),
		.din   ({ORBIT, OPERATOR_ACCEPT, OPERATOR_RESET, START_REQ}),
		.dout  ({orbit_d, ctl_d})
	);

	// Edge detection on synchronised levels, and on the raw STOP_REQ pin, so each request acts once.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			orbit_q <= 1'b0;
			ctl_q   <= 3'b000;
			stop_q  <= 1'b0;
		end else begin
			orbit_q <= orbit_d;
			ctl_q   <= ctl_d;
			stop_q  <= STOP_REQ;
		end
	end
	assign orbit_edge = orbit_d & ~orbit_q;
	assign opacc_edge = ctl_d[2] & ~ctl_q[2];
	assign oprst_edge = ctl_d[1] & ~ctl_q[1];
	assign start_edge = ctl_d[0] & ~ctl_q[0];
	assign stop_edge  = STOP_REQ & ~stop_q;

	// Inhibit combines every enabled participant each cycle; only global throttling results.
	assign busy_any    = (|(bsy & PART_ENABLE)) | ec_bsy;
	assign warn_any    = (|(wrn & PART_ENABLE)) | ec_wrn;
	assign inhibit_now = busy_any | warn_any | (rst_state != tcc_pkg::TCC_RUN) | ~RUNNING;

	// Ready and enabled partitions receive the decision of this crossing or an operator accept.
	assign fire = ({NP{~inhibit_now}} & PART_ENABLE & rdy) & (DECISION | {NP{opacc_edge}});

	// Channel A accept register: one crossing, one pulse, nothing else shares it.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			FIRST_LEVEL_ACCEPT <= '0;
		end else begin
			FIRST_LEVEL_ACCEPT <= fire;
		end
	end

	// Event coordinator record of the accept; the crossing stamp ties it to one crossing.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			EC_ACCEPT   <= 1'b0;
			EC_ALGO     <= '0;
			EC_TTYPE    <= '0;
			EC_XING_NUM <= '0;
		end else begin
			EC_ACCEPT <= |fire;
			if (|fire) begin
				EC_ALGO     <= ALGO_BITS;
				EC_XING_NUM <= xing;
				EC_TTYPE    <= ttype_pack(fire);
			end
		end
	end

	// Crossing counter wraps at orbit length and is cleared by the orbit signal.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			xing <= '0;
		end else if (orbit_edge || xing == tcc_pkg::XING_BITS'(tcc_pkg::ORBIT_LEN - 1)) begin
			xing <= '0;
		end else begin
			xing <= xing + 1'b1;
		end
	end

	// Event counter of accepts since the last clear, modulo 2^24.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			evt <= '0;
		end else if (rst_state == tcc_pkg::TCC_RECLR) begin
			evt <= '0;
		end else if (|fire) begin
			evt <= evt + 1'b1;
		end
	end
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			EC_EVT_NUM <= '0;
		end else begin
			EC_EVT_NUM <= evt;
		end
	end

	// Misalignment and error requests are caught on their rising level.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			mis_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			mis_q <= (|(mis & PART_ENABLE)) | ec_mis;
			err_q <= |(err & PART_ENABLE);
		end
	end
	assign rst_req  = (((|(mis & PART_ENABLE)) | ec_mis) & ~mis_q) | oprst_edge;
	assign deep_req = (|(err & PART_ENABLE)) & ~err_q;

	// Readout reset sequence: block accepts, send reset, wait, clear event number, resume.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			rst_state <= tcc_pkg::TCC_RUN;
			rst_cnt   <= '0;
		end else begin
			unique case (rst_state)
				tcc_pkg::TCC_RUN: begin
					if (rst_req) begin
						rst_state <= tcc_pkg::TCC_RSEND;
					end
				end
				tcc_pkg::TCC_RSEND: begin
					rst_state <= tcc_pkg::TCC_RWAIT;
					rst_cnt   <= '0;
				end
				tcc_pkg::TCC_RWAIT: begin
					if (rst_cnt == ($bits(rst_cnt))'(RST_WAIT - 1)) begin
						rst_state <= tcc_pkg::TCC_RECLR;
					end else begin
						rst_cnt <= rst_cnt + 1'b1;
					end
				end
				tcc_pkg::TCC_RECLR: begin
					rst_state <= tcc_pkg::TCC_RUN;
				end
			endcase
		end
	end

	// Coordinator gets the readout reset only; start/stop are not forwarded there.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			EC_READOUT_RESET <= 1'b0;
		end else begin
			EC_READOUT_RESET <= (rst_state == tcc_pkg::TCC_RSEND);
		end
	end

	// Run state follows start and stop requests.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			RUNNING <= 1'b0;
		end else if (start_edge) begin
			RUNNING <= 1'b1;
		end else if (stop_edge) begin
			RUNNING <= 1'b0;
		end
	end

	// Orbit and start/stop commands wait as pending flags; a new request wins over the clear.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			pend_orbit <= 1'b0;
			pend_xclr  <= 1'b0;
			pend_start <= 1'b0;
			pend_stop  <= 1'b0;
		end else begin
			pend_orbit <= orbit_edge | (pend_orbit & ~(LAUNCH_CMD == tcc_pkg::TCC_CMD_ORBIT));
			pend_xclr  <= orbit_edge | (pend_xclr & ~(LAUNCH_CMD == tcc_pkg::TCC_CMD_XCLR));
			pend_start <= start_edge | (pend_start & ~(LAUNCH_CMD == tcc_pkg::TCC_CMD_START));
			pend_stop  <= stop_edge | (pend_stop & ~(LAUNCH_CMD == tcc_pkg::TCC_CMD_STOP));
		end
	end

	// Launch strobes to all enabled partitions; resets take priority, markers pause in reset.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			LAUNCH     <= '0;
			LAUNCH_CMD <= tcc_pkg::TCC_CMD_NONE;
		end else begin
			LAUNCH     <= '0;
			LAUNCH_CMD <= tcc_pkg::TCC_CMD_NONE;
			if (deep_req) begin
				LAUNCH     <= PART_ENABLE;
				LAUNCH_CMD <= tcc_pkg::TCC_CMD_DRST;
			end else if (rst_state == tcc_pkg::TCC_RSEND) begin
				LAUNCH     <= PART_ENABLE;
				LAUNCH_CMD <= tcc_pkg::TCC_CMD_RRST;
			end else if (rst_state == tcc_pkg::TCC_RECLR) begin
				LAUNCH     <= PART_ENABLE;
				LAUNCH_CMD <= tcc_pkg::TCC_CMD_ECLR;
			end else if (rst_state != tcc_pkg::TCC_RUN) begin
				LAUNCH <= '0;
			end else if (pend_orbit && LAUNCH_CMD != tcc_pkg::TCC_CMD_ORBIT) begin
				LAUNCH     <= PART_ENABLE;
				LAUNCH_CMD <= tcc_pkg::TCC_CMD_ORBIT;
			end else if (pend_xclr && LAUNCH_CMD != tcc_pkg::TCC_CMD_XCLR) begin
				LAUNCH     <= PART_ENABLE;
				LAUNCH_CMD <= tcc_pkg::TCC_CMD_XCLR;
			end else if (pend_start && LAUNCH_CMD != tcc_pkg::TCC_CMD_START) begin
				LAUNCH     <= PART_ENABLE;
				LAUNCH_CMD <= tcc_pkg::TCC_CMD_START;
			end else if (pend_stop && LAUNCH_CMD != tcc_pkg::TCC_CMD_STOP) begin
				LAUNCH     <= PART_ENABLE;
				LAUNCH_CMD <= tcc_pkg::TCC_CMD_STOP;
			end
		end
	end

	// Trigger-type word is delayed by a fixed 1 us onto channel B.
	tcc_delay #(.W(32), .LAT(tcc_pkg::TTYPE_LAT_CYC)) u_ttype (
		.clk      (MCLK),
		.rst_n    (RST_N),
		.in_vld   ((|fire) & TTYPE_ON_B_EN),
		.in_data  (32'(ttype_pack(fire))),
		.out_vld  (ttype_vld),
		.out_data (b_word_dly)
	);

	function automatic logic [TW-1:0] ttype_pack(input logic [NP-1:0] f);
		logic [TW-1:0] r;
		r = '0;
		for (int i = 0; i < NP; i++) begin
			r[i*tcc_pkg::TTYPE_BITS +: tcc_pkg::TTYPE_BITS] = f[i] ? tcc_pkg::TTYPE_PHYSICS : tcc_pkg::TTYPE_NONE;
		end
		return r;
	endfunction

	// Channel B long words: delayed trigger type first, else event number at the event clear.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			B_WORD_VLD <= 1'b0;
			B_WORD     <= '0;
		end else if (ttype_vld) begin
			B_WORD_VLD <= 1'b1;
			B_WORD     <= b_word_dly;
		end else if (EVNUM_ON_B_EN && rst_state == tcc_pkg::TCC_RECLR) begin
			B_WORD_VLD <= 1'b1;
			B_WORD     <= {8'h00, evt};
		end else begin
			B_WORD_VLD <= 1'b0;
		end
	end

	// Dead-time counters: total inhibit, and the part caused by near-full warnings.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			INHIBIT         <= 1'b0;
			DEAD_COUNT      <= '0;
			WARN_DEAD_COUNT <= '0;
		end else begin
			INHIBIT <= inhibit_now;
			if (inhibit_now) begin
				DEAD_COUNT <= DEAD_COUNT + 1'b1;
			end
			if (warn_any) begin
				WARN_DEAD_COUNT <= WARN_DEAD_COUNT + 1'b1;
			end
		end
	end
endmodule // tcc_top

// File: hw/tcc_pkg.sv
// Shared constants for the trigger controller.
package tcc_pkg;
	localparam int NUM_PART        = 8;
	localparam int ALGO_BITS       = 128;
	localparam int TTYPE_BITS      = 4;
	localparam int EVT_BITS        = 24;
	localparam int XING_BITS       = 12;
	localparam int ORBIT_LEN       = 3564;
	localparam int CLK_MHZ         = 250;
	localparam int TTYPE_LAT_NS    = 1000;
	localparam int TTYPE_LAT_CYC   = (TTYPE_LAT_NS * CLK_MHZ) / 1000;
	localparam int RESET_WAIT_CYC  = 1000;
	localparam int DEAD_BITS       = 32;
	localparam logic [3:0] TTYPE_PHYSICS = 4'h1;
	localparam logic [3:0] TTYPE_NONE    = 4'h0;
	// Channel B command codes sent through the launch strobes.
	typedef enum logic [2:0] {
		TCC_CMD_NONE  = 3'b000,
		TCC_CMD_ORBIT = 3'b001,
		TCC_CMD_XCLR  = 3'b010,
		TCC_CMD_ECLR  = 3'b011,
		TCC_CMD_RRST  = 3'b100,
		TCC_CMD_DRST  = 3'b101,
		TCC_CMD_START = 3'b110,
		TCC_CMD_STOP  = 3'b111
	} tcc_cmd_t;
	typedef enum logic [1:0] {
		TCC_RUN   = 2'b00,
		TCC_RSEND = 2'b01,
		TCC_RWAIT = 2'b10,
		TCC_RECLR = 2'b11
	} tcc_rst_t;
endpackage

// File: hw/tcc_sync.sv
// Three-stage synchroniser for a pin-level bus; changes accepted when stages two and three agree.
`timescale 1ns/1ps
module tcc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// Stage one is only read by stage two to contain metastability.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Output follows each bit only once the last two stages agree.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dout <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					dout[i] <= s3[i];
				end
			end
		end
	end
endmodule // tcc_sync

// File: hw/tcc_delay.sv
// Fixed-latency delay line for the trigger-type word.
`timescale 1ns/1ps
module tcc_delay #(
	parameter int W   = 32,
	parameter int LAT = 250
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_vld,
	input  wire logic [W-1:0] in_data,
	output logic              out_vld,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] mem [LAT];
	logic [LAT-1:0] vld;

	if (LAT < 2) begin : g_lat_check
		$error("LAT must be at least 2");
	end

	// Shift register gives an exact latency at any accept rate.
	always_ff @(posedge clk) begin
		mem[0] <= in_data;
		for (int i = 1; i < LAT; i++) begin
			mem[i] <= mem[i-1];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vld <= '0;
		end else begin
			vld <= {vld[LAT-2:0], in_vld};
		end
	end

	assign out_vld  = vld[LAT-1];
	assign out_data = mem[LAT-1];
endmodule // tcc_delay

// File: dv/tcc_chk.sv
// Port-level assertions for the trigger controller, bound to its top module.
`timescale 1ns/1ps
module tcc_chk #(
	parameter int NP = 8
) (
	input wire logic                             MCLK,
	input wire logic                             RST_N,
	input wire logic                             ORBIT,
	input wire logic [tcc_pkg::ALGO_BITS-1:0]    ALGO_BITS,
	input wire logic                             TTYPE_ON_B_EN,
	input wire logic [NP-1:0]                    PART_ENABLE,
	input wire logic [NP-1:0]                    PART_MISALIGN,
	input wire logic [NP-1:0]                    PART_ERROR,
	input wire logic                             EC_MISALIGN,
	input wire logic [NP-1:0]                    FIRST_LEVEL_ACCEPT,
	input wire logic [NP-1:0]                    LAUNCH,
	input wire tcc_pkg::tcc_cmd_t                LAUNCH_CMD,
	input wire logic                             B_WORD_VLD,
	input wire logic                             EC_ACCEPT,
	input wire logic [tcc_pkg::ALGO_BITS-1:0]    EC_ALGO,
	input wire logic [NP*tcc_pkg::TTYPE_BITS-1:0] EC_TTYPE,
	input wire logic                             EC_READOUT_RESET,
	input wire logic [tcc_pkg::EVT_BITS-1:0]     EC_EVT_NUM,
	input wire logic [tcc_pkg::XING_BITS-1:0]    EC_XING_NUM,
	input wire logic                             INHIBIT,
	input wire logic                             RUNNING
);
	logic [NP*tcc_pkg::TTYPE_BITS-1:0] exp_tt;
	// Expected trigger-type nibbles follow the accept vector, so a misrouted nibble shows at once.
	always_comb begin
		for (int i = 0; i < NP; i++) begin
			exp_tt[i*4 +: 4] = FIRST_LEVEL_ACCEPT[i] ? tcc_pkg::TTYPE_PHYSICS : tcc_pkg::TTYPE_NONE;
		end
	end
	// All checks live in the one clock domain.
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	AST_INHIBIT_BLOCKS: assert property (INHIBIT [*3] |-> FIRST_LEVEL_ACCEPT == '0)
		else $error("accept issued while inhibited");
	AST_IDLE_BLOCKS: assert property (!RUNNING [*2] |-> FIRST_LEVEL_ACCEPT == '0)
		else $error("accept issued while stopped");
	AST_ONLY_ENABLED: assert property (FIRST_LEVEL_ACCEPT != '0 |-> (FIRST_LEVEL_ACCEPT & ~PART_ENABLE) == '0)
		else $error("accept sent to a partition outside the run");
	AST_EC_PAIRED: assert property (EC_ACCEPT == (FIRST_LEVEL_ACCEPT != '0))
		else $error("coordinator accept not paired with channel A accept");
	AST_EC_CONTENT: assert property (EC_ACCEPT |-> EC_TTYPE == exp_tt && EC_ALGO == $past(ALGO_BITS))
		else $error("coordinator trigger type or algorithm bits wrong");
	AST_EVT_STEP: assert property ($changed(EC_EVT_NUM) |->
		EC_EVT_NUM == 24'($past(EC_EVT_NUM) + 24'h1) || EC_EVT_NUM == '0)
		else $error("event number moved by other than one");
	AST_XING_RANGE: assert property (EC_XING_NUM < 12'hdec)
		else $error("crossing number beyond one orbit");
	AST_TTYPE_LATENCY: assert property (EC_ACCEPT && TTYPE_ON_B_EN |-> ##250 B_WORD_VLD)
		else $error("trigger type word not sent on channel B in time");
	AST_MISALIGN_RESET: assert property ($rose(|(PART_MISALIGN & PART_ENABLE) | EC_MISALIGN) |->
		##[1:12] EC_READOUT_RESET)
		else $error("misalignment gave no readout reset");
	// The quiet span assumes RST_WAIT of at least eight cycles, as the bench sets.
	AST_RESET_QUIET: assert property (EC_READOUT_RESET |->
		LAUNCH != '0 && LAUNCH_CMD == tcc_pkg::TCC_CMD_RRST ##1 (FIRST_LEVEL_ACCEPT == '0) [*8])
		else $error("readout reset not launched or accepts not shut off");
	AST_DEEP_RESET: assert property ($rose(|(PART_ERROR & PART_ENABLE)) |->
		##[1:12] (LAUNCH != '0 && LAUNCH_CMD == tcc_pkg::TCC_CMD_DRST))
		else $error("error state gave no deep reset");
	AST_ORBIT_MARK: assert property ($rose(ORBIT) |-> ##[1:12] (LAUNCH != '0 && LAUNCH_CMD == tcc_pkg::TCC_CMD_ORBIT))
		else $error("orbit edge gave no orbit marker");
endmodule // tcc_chk

bind tcc_top tcc_chk #(.NP(NP)) tcc_chk_i (.MCLK(MCLK), .RST_N(RST_N), .ORBIT(ORBIT), .ALGO_BITS(ALGO_BITS),
	.TTYPE_ON_B_EN(TTYPE_ON_B_EN), .PART_ENABLE(PART_ENABLE), .PART_MISALIGN(PART_MISALIGN),
	.PART_ERROR(PART_ERROR), .EC_MISALIGN(EC_MISALIGN), .FIRST_LEVEL_ACCEPT(FIRST_LEVEL_ACCEPT), .LAUNCH(LAUNCH),
	.LAUNCH_CMD(LAUNCH_CMD), .B_WORD_VLD(B_WORD_VLD), .EC_ACCEPT(EC_ACCEPT), .EC_ALGO(EC_ALGO), .EC_TTYPE(EC_TTYPE),
	.EC_READOUT_RESET(EC_READOUT_RESET), .EC_EVT_NUM(EC_EVT_NUM), .EC_XING_NUM(EC_XING_NUM), .INHIBIT(INHIBIT),
	.RUNNING(RUNNING));

// File: dv/tcc_part_model.sv
// Behavioural model of partition and coordinator status feedback.
`timescale 1ns/1ps
module tcc_part_model #(
	parameter int NP = 8
) (
	input  wire logic          clk,
	input  wire logic [NP-1:0] req_busy,
	input  wire logic [NP-1:0] req_warn,
	input  wire logic [NP-1:0] req_mis,
	input  wire logic [NP-1:0] req_err,
	input  wire logic [2:0]    req_ec,
	output logic      [NP-1:0] ready,
	output logic      [NP-1:0] busy,
	output logic      [NP-1:0] warn,
	output logic      [NP-1:0] mis,
	output logic      [NP-1:0] err,
	output logic               ec_busy,
	output logic               ec_warn,
	output logic               ec_mis
);
	logic [5*NP+2:0] pipe;
	// Status is recombined every cycle and passes two fixed stages, so its latency never varies.
	always_ff @(posedge clk) begin
		pipe <= {req_ec, req_err, req_mis, req_warn, req_busy, ~(req_busy | req_err)};
		{ec_mis, ec_warn, ec_busy, err, mis, warn, busy, ready} <= pipe;
	end
endmodule // tcc_part_model

// File: dv/tcc_tb.sv
// Self-checking bench for the trigger controller.
`timescale 1ns/1ps
module tb;
	localparam int NP = tcc_pkg::NUM_PART;
	logic mclk = 1'b0, rst_n = 1'b0, orbit = 1'b0, op_acc = 1'b0, op_rst = 1'b0, start = 1'b0, stop = 1'b0, ben = 1'b1;
	logic [7:0] dec = '0, en = 8'hef, r_busy = '0, r_warn = '0, r_mis = '0, r_err = '0;
	logic [2:0] r_ec = '0;
	logic [127:0] algo = '0, ealgo;
	logic [7:0] rdy, bsy, wrn, mis, err, fla, lau;
	logic ec_b, ec_w, ec_m, bvld, eacc, errst, inh, run;
	tcc_pkg::tcc_cmd_t lcmd;
	logic [31:0] bword, dead, wdead, lastw, ett, seed = 32'h2c, w0, d0;
	logic [23:0] evt, evc = '0;
	logic [11:0] xing;
	int fails = 0, n_tests = 0, nacc = 0, n0, nb = 0;
	int cnt [8];

	always #2 mclk = ~mclk;

	tcc_top #(.RST_WAIT(8)) tcc_top_i (.MCLK(mclk), .RST_N(rst_n), .ORBIT(orbit), .DECISION(dec), .ALGO_BITS(algo),
		.OPERATOR_ACCEPT(op_acc), .OPERATOR_RESET(op_rst), .START_REQ(start), .STOP_REQ(stop), .TTYPE_ON_B_EN(ben),
		.EVNUM_ON_B_EN(1'b1), .PART_ENABLE(en), .PART_READY(rdy), .PART_BUSY(bsy), .PART_WARN(wrn),
		.PART_MISALIGN(mis), .PART_ERROR(err), .EC_BUSY(ec_b), .EC_WARN(ec_w), .EC_MISALIGN(ec_m),
		.FIRST_LEVEL_ACCEPT(fla), .LAUNCH(lau), .LAUNCH_CMD(lcmd), .B_WORD_VLD(bvld), .B_WORD(bword),
		.EC_ACCEPT(eacc), .EC_ALGO(ealgo), .EC_TTYPE(ett), .EC_READOUT_RESET(errst), .EC_EVT_NUM(evt),
		.EC_XING_NUM(xing), .INHIBIT(inh), .DEAD_COUNT(dead), .WARN_DEAD_COUNT(wdead), .RUNNING(run));
	tcc_part_model #(.NP(NP)) tcc_part_model_i (.clk(mclk), .req_busy(r_busy), .req_warn(r_warn), .req_mis(r_mis),
		.req_err(r_err), .req_ec(r_ec), .ready(rdy), .busy(bsy), .warn(wrn), .mis(mis), .err(err),
		.ec_busy(ec_b), .ec_warn(ec_w), .ec_mis(ec_m));

	// Launches, accepts and channel B words are tallied as they pass, for checks at quiet points.
	always @(posedge mclk) begin
		if (lau != '0) cnt[lcmd] <= cnt[lcmd] + 1;
		if (fla != '0) nacc <= nacc + 1;
		if (bvld) lastw <= bword;
		if (bvld) nb <= nb + 1;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// Expected trigger-type word: one nibble per partition, partition 0 lowest.
	function automatic logic [31:0] ttw(input logic [7:0] a);
		logic [31:0] w;
		w = '0;
		for (int i = 0; i < NP; i++) w[i*4 +: 4] = a[i] ? tcc_pkg::TTYPE_PHYSICS : tcc_pkg::TTYPE_NONE;
		return w;
	endfunction

	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		n_tests++;
		if (e !== g) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// A hang is cut off well past the roughly 1300 cycles the sequence needs.
	initial begin
		#40000;
		fails++;
		print_verdict();
	end

	initial begin
		cyc(16);
		rst_n = 1'b1;
		cyc(2);
		chk("running", 0, run);
		start = 1'b1;
		cyc(10);
		chk("running", 1, run);
		chk("start", 1, cnt[tcc_pkg::TCC_CMD_START]);
		// Partition 4 is outside the run, so its busy must not throttle anyone.
		r_busy = 8'h10;
		cyc(8);
		for (int k = 0; k < 300; k++) begin
			seed = xs(seed);
			dec = seed[7:0];
			algo = {seed, ~seed, seed, 32'(k)};
			if ((dec & en) != '0) evc++;
			cyc(1);
			chk("accept", dec & en, fla);
			if ((dec & en) != '0) chk("ttype", ttw(dec & en), ett);
			if ((dec & en) != '0) chk("algo", algo, ealgo);
		end
		dec = '0;
		cyc(2);
		chk("event number", evc, evt);
		// Each throttling source in turn: partition busy, partition warn, coordinator busy, coordinator warn.
		for (int s = 0; s < 4; s++) begin
			case (s)
				0: r_busy = 8'h12;
				1: r_warn = 8'h02;
				2: r_ec = 3'b001;
				default: r_ec = 3'b010;
			endcase
			cyc(8);
			w0 = wdead;
			d0 = dead;
			n0 = nacc;
			dec = en;
			cyc(20);
			chk("inhibit", 1, inh);
			chk("blocked", n0, nacc);
			chk("dead", 20, dead - d0);
			chk("warn dead", (s % 2) * 20, wdead - w0);
			dec = '0;
			r_busy = 8'h10;
			r_warn = '0;
			r_ec = '0;
			cyc(10);
			w0 = wdead;
			cyc(10);
			chk("warn dead hold", w0, wdead);
			chk("inhibit", 0, inh);
		end
		n0 = nacc;
		op_acc = 1'b1;
		cyc(10);
		op_acc = 1'b0;
		chk("operator accept", n0 + 1, nacc);
		dec = 8'h05;
		cyc(1);
		dec = '0;
		cyc(252);
		chk("b word", ttw(8'h05), lastw);
		// With the channel B option off, an accept must leave no trigger-type word behind.
		n0 = nb;
		ben = 1'b0;
		dec = 8'h05;
		cyc(1);
		dec = '0;
		cyc(252);
		chk("b word count", n0, nb);
		evc = evc + 24'h3; // Operator accept and the two single accepts.
		cnt = '{default: 0};
		orbit = 1'b1;
		cyc(20);
		chk("orbit marker", 1, cnt[tcc_pkg::TCC_CMD_ORBIT]);
		chk("crossing clear", 1, cnt[tcc_pkg::TCC_CMD_XCLR]);
		orbit = 1'b0;
		// Reset sources: partition misalign, coordinator misalign, operator, partition error.
		for (int s = 0; s < 4; s++) begin
			cnt = '{default: 0};
			case (s)
				0: r_mis = 8'h01;
				1: r_ec = 3'b100;
				2: op_rst = 1'b1;
				default: r_err = 8'h04;
			endcase
			cyc(40);
			chk("readout reset", s < 3, cnt[tcc_pkg::TCC_CMD_RRST]);
			chk("event clear", s < 3, cnt[tcc_pkg::TCC_CMD_ECLR]);
			chk("deep reset", s == 3, cnt[tcc_pkg::TCC_CMD_DRST]);
			if (s < 3) chk("event number", 0, evt);
			if (s < 3) chk("event word", {8'h00, evc}, lastw);
			evc = '0;
			r_mis = '0;
			r_ec = '0;
			op_rst = 1'b0;
			r_err = '0;
			cyc(10);
		end
		cnt = '{default: 0};
		stop = 1'b1;
		cyc(10);
		chk("running", 0, run);
		chk("stop", 1, cnt[tcc_pkg::TCC_CMD_STOP]);
		print_verdict();
	end
endmodule // tb
